// file: cbus_defines.vh
// constants for the configurable control-bus pin and the 4-bit port
// assumes a 100 MHz system clock and a 5-bit option code from the config store
`ifndef CBUS_DEFINES_VH
`define CBUS_DEFINES_VH

// ==========================================================
// option codes held in the config store
`define OPT_WIDTH          5
`define OPT_TRISTATE       5'h00
`define OPT_DRIVE_ONE      5'h01
`define OPT_DRIVE_ZERO     5'h02
`define OPT_POWER_SWITCH   5'h03
`define OPT_SLEEP          5'h04
`define OPT_CLK_FAST       5'h05
`define OPT_CLK_MID        5'h06
`define OPT_CLK_SLOW       5'h07
`define OPT_GPIO           5'h08
`define OPT_CHARGER        5'h09
`define OPT_CHARGER_N      5'h0A
`define OPT_WRITE_STROBE   5'h0B
`define OPT_READ_STROBE    5'h0C
`define OPT_BUS_POWER      5'h0D
`define OPT_TIMESTAMP      5'h0E
`define OPT_STAY_AWAKE     5'h0F

// ==========================================================
// register map (byte addresses, 8-bit address port)
`define ADDR_WIDTH         8
`define REG_CONTROL        8'h00
`define REG_STATUS         8'h04
`define REG_PORT_OUT       8'h08
`define REG_PRESCALE       8'h0C
`define REG_PORT_IN        8'h10
`define REG_PORT_DIR       8'h14

// control register fields
`define CTL_GPIO_OE        0
`define CTL_GPIO_LEVEL     1
`define CTL_MODE_LO        4
`define CTL_MODE_HI        5

// port modes
`define MODE_OFF           2'h0
`define MODE_ASYNC         2'h1
`define MODE_SYNC          2'h2

// reset values
`define RST_CONTROL        32'h0000_0000
`define RST_PRESCALE       16'h0063
`define RST_PORT_DIR       4'h0

// ==========================================================
// clock outputs: phase increments on a 16-bit accumulator
// the accumulator carries at twice the output frequency
`define CLK_MHZ            100
`define ACC_ONE            65536
`define FAST_MHZ           24
`define MID_MHZ            12
`define SLOW_MHZ           6
`define CLK_INC(mhz)       (((mhz) * 2 * `ACC_ONE) / `CLK_MHZ)

`endif

// file: rate_divider.v
// phase accumulator that emits a one-cycle enable at an average rate
// assumes inc is below half the accumulator range
`timescale 1ns/1ps

module rate_divider #(
  parameter [15:0] INC = 16'h0001
) (
  input  wire clk,
  input  wire rst,
  input  wire run,
  output reg  tick
);

  reg [15:0] acc_q;
  wire [16:0] sum = {1'b0, acc_q} + {1'b0, INC};

  // ==========================================================
  // accumulate; stopping clears phase so restart is repeatable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (!run) begin
      acc_q <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      acc_q <= sum[15:0];
      tick  <= sum[16];
    end
  end

endmodule // rate_divider

// file: cbus_pin_function_select.v
// configurable control-bus pin multiplexer and 4-bit bit-bang port
// assumes usb core status inputs are synchronous to clk and the config
// store code is stable from reset release onward
//
// What this block does
// - one configurable pin, its function picked by a stored option code.
// - exactly one option is active at a time, from the latched code.
// - static options tri-state the pin, drive constant one or constant zero.
// - power-switch option drives low once configured, high during suspend.
// - sleep option drives low while suspended, high otherwise.
// - clock options output free-running 24, 12 or 6 MHz.
// - selected clock output stops toggling while suspended.
// - gpio option: software sets pin direction and level over registers.
// - charger option drives high when on a dedicated charging port.
// - inverted charger option is open-drain, pulls low only when charging.
// - write-strobe option pulses pin low per bit-bang output transfer.
// - read-strobe option pulses pin low per bit-bang input sample.
// - bus-power option samples pin as input indicating bus power present.
// - timestamp option toggles pin on every start-of-frame received.
// - stay-awake option: active-low input holding off suspend when unplugged.
// - bit-bang mode turns the four data lines into a 4-bit port.
// - async mode sends written words one by one, paced by a prescaler.
// - sync mode samples the port only right after each written word.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "cbus_defines.vh"

module cbus_pin_function_select (
  input  wire                    clk,
  input  wire                    rst,
  // config store and usb core status
  input  wire [`OPT_WIDTH-1:0]   option_code,
  input  wire                    usb_configured,
  input  wire                    usb_suspend,
  input  wire                    charger_port_detect,
  input  wire                    sof_received,
  // configurable pin
  input  wire                    config_pin_in,
  output reg                     config_pin_out,
  output reg                     config_pin_oe_n,
  // pin-derived status towards the usb core
  output reg                     bus_power_detect,
  output reg                     suspend_inhibit,
  // interface data lines
  input  wire [3:0]              proto_data_out,
  input  wire [3:0]              proto_data_oe_n,
  input  wire [3:0]              interface_data_lines_in,
  output reg  [3:0]              interface_data_lines_out,
  output reg  [3:0]              interface_data_lines_oe_n,
  // register port
  input  wire [`ADDR_WIDTH-1:0]  reg_addr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_write,
  input  wire                    reg_read,
  output reg  [31:0]             reg_rdata
);

  // ==========================================================
  // option latch
  reg [`OPT_WIDTH-1:0] option_q;
  reg                  loaded_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      option_q <= `OPT_TRISTATE;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      option_q <= option_code;
      loaded_q <= 1'b1;
    end
  end

  // ==========================================================
  // software registers
  reg [31:0] control_q;
  reg [15:0] prescale_q;
  reg [3:0]  port_dir_q;
  reg [3:0]  hold_q;
  reg        pending_q;
  reg [3:0]  port_in_q;

  wire       wr_control  = reg_write && (reg_addr == `REG_CONTROL);
  wire       wr_port_out = reg_write && (reg_addr == `REG_PORT_OUT);
  wire       wr_prescale = reg_write && (reg_addr == `REG_PRESCALE);
  wire       wr_port_dir = reg_write && (reg_addr == `REG_PORT_DIR);
  wire [1:0] mode        = control_q[`CTL_MODE_HI:`CTL_MODE_LO];
  wire       bb_active   = (mode == `MODE_ASYNC) || (mode == `MODE_SYNC);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      control_q  <= `RST_CONTROL;
      prescale_q <= `RST_PRESCALE;
      port_dir_q <= `RST_PORT_DIR;
    end else begin
      if (wr_control) begin
        control_q <= {26'h000_0000, reg_wdata[5:4], 2'b00, reg_wdata[1:0]};
      end
      if (wr_prescale) begin
        prescale_q <= reg_wdata[15:0];
      end
      if (wr_port_dir) begin
        port_dir_q <= reg_wdata[3:0];
      end
    end
  end

  // ==========================================================
  // async pacing timer, works like a baud prescaler
  reg [15:0] pace_cnt_q;
  wire       pace_tick = (mode == `MODE_ASYNC) && (pace_cnt_q >= prescale_q);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pace_cnt_q <= 16'h0000;
    end else if (mode != `MODE_ASYNC || pace_tick) begin
      pace_cnt_q <= 16'h0000;
    end else begin
      pace_cnt_q <= pace_cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // bit-bang port engine
  reg [3:0] bb_out_q;
  reg       wr_strobe_n_q;
  reg       rd_strobe_n_q;
  reg       sample_due_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bb_out_q      <= 4'h0;
      hold_q        <= 4'h0;
      pending_q     <= 1'b0;
      port_in_q     <= 4'h0;
      wr_strobe_n_q <= 1'b1;
      rd_strobe_n_q <= 1'b1;
      sample_due_q  <= 1'b0;
    end else begin
      wr_strobe_n_q <= 1'b1;
      rd_strobe_n_q <= 1'b1;
      sample_due_q  <= 1'b0;
      if (mode == `MODE_ASYNC) begin
        // a word written in the tick cycle is kept, not lost
        if (pace_tick) begin
          port_in_q     <= interface_data_lines_in;
          rd_strobe_n_q <= 1'b0;
          if (pending_q) begin
            bb_out_q      <= hold_q;
            wr_strobe_n_q <= 1'b0;
            pending_q     <= 1'b0;
          end
        end
        if (wr_port_out) begin
          hold_q    <= reg_wdata[3:0];
          pending_q <= 1'b1;
        end
      end else if (mode == `MODE_SYNC) begin
        pending_q <= 1'b0;
        if (wr_port_out) begin
          bb_out_q      <= reg_wdata[3:0];
          wr_strobe_n_q <= 1'b0;
          sample_due_q  <= 1'b1;
        end
        // pins are read once, the cycle after the new word goes out
        if (sample_due_q) begin
          port_in_q     <= interface_data_lines_in;
          rd_strobe_n_q <= 1'b0;
        end
      end else begin
        pending_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // data line steering
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      interface_data_lines_out  <= 4'h0;
      interface_data_lines_oe_n <= 4'hF;
    end else if (bb_active) begin
      interface_data_lines_out  <= bb_out_q;
      interface_data_lines_oe_n <= ~port_dir_q;
    end else begin
      interface_data_lines_out  <= proto_data_out;
      interface_data_lines_oe_n <= proto_data_oe_n;
    end
  end

  // ==========================================================
  // clock outputs; suspend holds them low
  wire [2:0] clk_tick;
  reg  [2:0] clk_lvl_q;

  function [15:0] clk_inc;
    input integer idx;
    reg [31:0] full;
    begin
      case (idx)
        0:       full = `CLK_INC(`FAST_MHZ);
        1:       full = `CLK_INC(`MID_MHZ);
        default: full = `CLK_INC(`SLOW_MHZ);
      endcase
      clk_inc = full[15:0];
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_clk
      rate_divider #(
        .INC (clk_inc(gi))
      ) u_div (
        .clk  (clk),
        .rst  (rst),
        .run  (!usb_suspend),
        .tick (clk_tick[gi])
      );

      always @(posedge clk or posedge rst) begin
        if (rst) begin
          clk_lvl_q[gi] <= 1'b0;
        end else if (usb_suspend) begin
          clk_lvl_q[gi] <= 1'b0;
        end else if (clk_tick[gi]) begin
          clk_lvl_q[gi] <= ~clk_lvl_q[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // start-of-frame toggle
  reg stamp_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stamp_q <= 1'b0;
    end else if (sof_received) begin
      stamp_q <= ~stamp_q;
    end
  end

  // ==========================================================
  // pin multiplexer
  reg pin_out_d;
  reg pin_oe_n_d;

  always @* begin
    pin_out_d  = 1'b0;
    pin_oe_n_d = 1'b1;
    case (option_q)
      `OPT_TRISTATE: begin
        pin_oe_n_d = 1'b1;
      end
      `OPT_DRIVE_ONE: begin
        pin_out_d  = 1'b1;
        pin_oe_n_d = 1'b0;
      end
      `OPT_DRIVE_ZERO: begin
        pin_out_d  = 1'b0;
        pin_oe_n_d = 1'b0;
      end
      `OPT_POWER_SWITCH: begin
        pin_out_d  = !(usb_configured && !usb_suspend);
        pin_oe_n_d = 1'b0;
      end
      `OPT_SLEEP: begin
        pin_out_d  = !usb_suspend;
        pin_oe_n_d = 1'b0;
      end
      `OPT_CLK_FAST: begin
        pin_out_d  = clk_lvl_q[0];
        pin_oe_n_d = 1'b0;
      end
      `OPT_CLK_MID: begin
        pin_out_d  = clk_lvl_q[1];
        pin_oe_n_d = 1'b0;
      end
      `OPT_CLK_SLOW: begin
        pin_out_d  = clk_lvl_q[2];
        pin_oe_n_d = 1'b0;
      end
      `OPT_GPIO: begin
        pin_out_d  = control_q[`CTL_GPIO_LEVEL];
        pin_oe_n_d = !control_q[`CTL_GPIO_OE];
      end
      `OPT_CHARGER: begin
        pin_out_d  = charger_port_detect;
        pin_oe_n_d = 1'b0;
      end
      `OPT_CHARGER_N: begin
        pin_out_d  = 1'b0;
        pin_oe_n_d = !charger_port_detect;
      end
      `OPT_WRITE_STROBE: begin
        pin_out_d  = wr_strobe_n_q;
        pin_oe_n_d = 1'b0;
      end
      `OPT_READ_STROBE: begin
        pin_out_d  = rd_strobe_n_q;
        pin_oe_n_d = 1'b0;
      end
      `OPT_BUS_POWER: begin
        pin_oe_n_d = 1'b1;
      end
      `OPT_TIMESTAMP: begin
        pin_out_d  = stamp_q;
        pin_oe_n_d = 1'b0;
      end
      `OPT_STAY_AWAKE: begin
        pin_oe_n_d = 1'b1;
      end
      default: begin
        pin_oe_n_d = 1'b1;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      config_pin_out   <= 1'b0;
      config_pin_oe_n  <= 1'b1;
      bus_power_detect <= 1'b0;
      suspend_inhibit  <= 1'b0;
    end else begin
      config_pin_out   <= pin_out_d;
      config_pin_oe_n  <= pin_oe_n_d;
      bus_power_detect <= (option_q == `OPT_BUS_POWER) && config_pin_in;
      // low on the pin holds the device awake even when unplugged
      suspend_inhibit  <= (option_q == `OPT_STAY_AWAKE) && !config_pin_in;
    end
  end

  // ==========================================================
  // register read port; unmapped reads return zero
  wire [31:0] status_word = {23'h00_0000, option_q, pending_q, suspend_inhibit,
                             bus_power_detect, config_pin_in};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        `REG_CONTROL:  reg_rdata <= control_q;
        `REG_STATUS:   reg_rdata <= status_word;
        `REG_PORT_OUT: reg_rdata <= {28'h000_0000, bb_out_q};
        `REG_PRESCALE: reg_rdata <= {16'h0000, prescale_q};
        `REG_PORT_IN:  reg_rdata <= {28'h000_0000, port_in_q};
        `REG_PORT_DIR: reg_rdata <= {28'h000_0000, port_dir_q};
        default:       reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // cbus_pin_function_select

// file: cbus_pin_monitor.sv
// assertion checker for the configurable control-bus pin
// sees only top-level ports; option_code is taken once, on the first edge after reset
`timescale 1ns/1ps
`include "cbus_defines.vh"
module cbus_pin_monitor (
  input logic                  clk,
  input logic                  rst,
  input logic [`OPT_WIDTH-1:0] option_code,
  input logic                  usb_configured,
  input logic                  usb_suspend,
  input logic                  charger_port_detect,
  input logic                  sof_received,
  input logic                  config_pin_in,
  input logic                  config_pin_out,
  input logic                  config_pin_oe_n,
  input logic                  bus_power_detect,
  input logic                  suspend_inhibit,
  input logic                  reg_read,
  input logic [31:0]           reg_rdata
);
  // ==========================================================
  // settle counter: the pin shows its function two edges after reset
  logic [1:0] age_q;
  logic [4:0] opt;
  wire        ok = (age_q == 2'h3);
  // the code is taken once after reset; later changes on the input do not count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_q <= 2'h0;
      opt   <= `OPT_TRISTATE;
    end else if (!ok) begin
      age_q <= age_q + 2'h1;
      if (age_q == 2'h0) opt <= option_code;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // properties
  property p_static;
    ok && opt inside {`OPT_DRIVE_ONE, `OPT_DRIVE_ZERO} |->
      !config_pin_oe_n && config_pin_out == (opt == `OPT_DRIVE_ONE);
  endproperty
  a_static: assert property (p_static) else $error("constant drive wrong");
  property p_float;
    ok && (opt == `OPT_TRISTATE || opt >= 5'h10) |-> config_pin_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("pin not released");
  property p_power;
    ok && opt == `OPT_POWER_SWITCH |=> !config_pin_oe_n &&
      config_pin_out == !($past(usb_configured) && !$past(usb_suspend));
  endproperty
  a_power: assert property (p_power) else $error("power switch level wrong");
  property p_sleep;
    ok && opt == `OPT_SLEEP |=> config_pin_out == !$past(usb_suspend);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep level wrong");
  property p_clk_stop;
    // the level flop clears first, the pin flop follows one edge later
    ok && opt inside {[`OPT_CLK_FAST:`OPT_CLK_SLOW]} && usb_suspend ##1 usb_suspend
      |=> !config_pin_out;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock runs in suspend");
  property p_charger;
    ok && opt == `OPT_CHARGER |=> config_pin_out == $past(charger_port_detect);
  endproperty
  a_charger: assert property (p_charger) else $error("charger flag wrong");
  property p_charger_n;
    ok && opt == `OPT_CHARGER_N |=> config_pin_oe_n == !$past(charger_port_detect)
      && (config_pin_oe_n || !config_pin_out);
  endproperty
  a_charger_n: assert property (p_charger_n) else $error("open-drain flag wrong");
  property p_stamp;
    ok && opt == `OPT_TIMESTAMP && sof_received |-> ##2 config_pin_out != $past(config_pin_out);
  endproperty
  a_stamp: assert property (p_stamp) else $error("frame toggle missing");
  property p_sense;
    ok && opt == `OPT_BUS_POWER |=> bus_power_detect == $past(config_pin_in) && config_pin_oe_n;
  endproperty
  a_sense: assert property (p_sense) else $error("bus power sense wrong");
  property p_awake;
    ok && opt == `OPT_STAY_AWAKE |=> suspend_inhibit == !$past(config_pin_in);
  endproperty
  a_awake: assert property (p_awake) else $error("stay-awake wrong");
  property p_rdata;
    !reg_read |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data without read");
  c_stamp: cover property (ok && opt == `OPT_TIMESTAMP && sof_received);
  c_clk_stop: cover property (ok && opt == `OPT_CLK_SLOW && usb_suspend);
  c_sense: cover property (ok && bus_power_detect);
endmodule // cbus_pin_monitor

// file: pin_far_side.sv
// far-side model: board pull resistor, a controller on the pin and data lines
// assumes device enables are active low and the bench steers the controller
`timescale 1ns/1ps
module pin_far_side (
  input  logic       clk,
  input  logic       pin_out,
  input  logic       pin_oe_n,
  input  logic       pull_down,
  input  logic       hold_en,
  input  logic       hold_level,
  input  logic [3:0] lines_out,
  input  logic [3:0] lines_oe_n,
  input  logic [3:0] ext_word,
  output logic       pin_level,
  output logic [3:0] lines_level,
  output logic [7:0] falls
);
  logic last_q = 1'b1;
  initial falls = 8'h00;
  // released pin goes to hold_level while hold_en is set, else to the resistor level, never to a stale value
  assign pin_level = !pin_oe_n ? pin_out : hold_en ? hold_level : !pull_down;
  assign lines_level = (lines_out & ~lines_oe_n) | (ext_word & lines_oe_n);
  // strobes are counted by falling edges seen at the clock
  always @(posedge clk) begin
    last_q <= pin_level;
    if (last_q && !pin_level) falls <= falls + 8'h01;
  end
endmodule // pin_far_side

// file: test_cbus_pin_function_select.sv
// self-checking bench for the configurable pin and the bit-bang port
// assumes pin_far_side on the pin and data lines, checker bound below
`timescale 1ns/1ps
`include "cbus_defines.vh"
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("BAD t=%0t got %h want %h", $time, (g), (e)); \
  end \
end
module test_cbus_pin_function_select;
  logic        clk = 1'b0, rst = 1'b1, usb_configured = 1'b0, usb_suspend = 1'b0;
  logic        charger_port_detect = 1'b0, sof_received = 1'b0, reg_write = 1'b0;
  logic        reg_read = 1'b0, pull_down = 1'b0, hold_en = 1'b0, hold_level = 1'b0;
  logic [4:0]  option_code = 5'h00;
  logic [3:0]  proto_data_out = 4'h0, proto_data_oe_n = 4'hF, ext_word = 4'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic [3:0]  interface_data_lines_in, interface_data_lines_out, interface_data_lines_oe_n;
  logic        config_pin_in, config_pin_out, config_pin_oe_n, bus_power_detect;
  logic        suspend_inhibit, last;
  logic [7:0]  falls;
  int          n_mismatch = 0, samples_checked = 0, cycles = 0, n, f;
  int          mhz [3] = '{`FAST_MHZ, `MID_MHZ, `SLOW_MHZ};
  logic [4:0]  st_opt [5] = '{5'h00, 5'h01, 5'h02, 5'h10, 5'h1F};
  logic [1:0]  st_exp [5] = '{2'b11, 2'b01, 2'b00, 2'b11, 2'b11};

  cbus_pin_function_select i_dut (.clk, .rst, .option_code, .usb_configured, .usb_suspend,
    .charger_port_detect, .sof_received, .config_pin_in, .config_pin_out, .config_pin_oe_n,
    .bus_power_detect, .suspend_inhibit, .proto_data_out, .proto_data_oe_n,
    .interface_data_lines_in, .interface_data_lines_out, .interface_data_lines_oe_n,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  pin_far_side i_far (.clk, .pin_out(config_pin_out), .pin_oe_n(config_pin_oe_n), .pull_down,
    .hold_en, .hold_level, .lines_out(interface_data_lines_out),
    .lines_oe_n(interface_data_lines_oe_n), .ext_word, .pin_level(config_pin_in),
    .lines_level(interface_data_lines_in), .falls);

  initial forever #5 clk = ~clk;
  // ==========================================================
  // bus and check helpers
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
  endtask
  // the option is latched only once after reset, so each option needs one
  task automatic start(logic [4:0] o);
    rst <= 1'b1;
    option_code <= o;
    cyc(16);
    rst <= 1'b0;
    cyc(4);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] w);
    // a write just issued still shows its strobe: let one edge pass first
    if (reg_write) @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] r);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    r = reg_rdata;
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    `CHK(r, e)
  endtask
  // a released pin reads as 11 so its stale data bit is ignored
  task automatic pin(logic [1:0] e);
    `CHK({config_pin_oe_n, config_pin_out | config_pin_oe_n}, e)
  endtask
  task automatic rises(int len, output int k);
    logic p;
    k = 0;
    p = config_pin_out;
    repeat (len) begin
      @(posedge clk);
      k += int'(config_pin_out && !p);
      p = config_pin_out;
    end
  endtask
  task automatic wait_word(logic [3:0] w, output int k);
    k = 0;
    while (interface_data_lines_out !== w && k < 100) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    foreach (st_opt[i]) begin
      start(st_opt[i]);
      pin(st_exp[i]);
    end
    rdc(`REG_CONTROL, 32'h0000_0000);
    rdc(`REG_PRESCALE, 32'h0000_0063);
    rdc(`REG_PORT_DIR, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0000_0000);
    wr(`REG_STATUS, 32'h0000_0000);
    rdc(`REG_STATUS, 32'h0000_01F1);
    option_code <= 5'h01;
    cyc(3);
    pin(2'b11);
    start(`OPT_POWER_SWITCH);
    pull_down <= 1'b1;
    pin(2'b01);
    usb_configured <= 1'b1;
    cyc(2);
    pin(2'b00);
    usb_suspend <= 1'b1;
    cyc(2);
    pin(2'b01);
    pull_down <= 1'b0;
    start(`OPT_SLEEP);
    pin(2'b00);
    usb_suspend <= 1'b0;
    cyc(2);
    pin(2'b01);
    for (int k = 0; k < 3; k++) begin
      start(5'(`OPT_CLK_FAST + k));
      rises(1000, n);
      `CHK(n inside {[mhz[k] * 10 - 2 : mhz[k] * 10 + 2]}, 1'b1)
      usb_suspend <= 1'b1;
      cyc(2);
      rises(50, n);
      `CHK({n, config_pin_out}, {32'd0, 1'b0})
      usb_suspend <= 1'b0;
    end
    start(`OPT_GPIO);
    wr(`REG_CONTROL, 32'h0000_0003);
    cyc(2);
    pin(2'b01);
    wr(`REG_CONTROL, 32'h0000_0001);
    cyc(2);
    pin(2'b00);
    wr(`REG_CONTROL, 32'h0000_0000);
    hold_en <= 1'b1;
    cyc(3);
    rdc(`REG_STATUS, 32'h0000_0080);
    for (int k = 0; k < 4; k++) begin
      if (k % 2 == 0) start(k < 2 ? `OPT_BUS_POWER : `OPT_STAY_AWAKE);
      hold_level <= k[0];
      cyc(3);
      `CHK({config_pin_oe_n, bus_power_detect, suspend_inhibit}, {1'b1, k < 2 && k[0], k >= 2 && !k[0]})
    end
    hold_en <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      start(k < 2 ? `OPT_CHARGER : `OPT_CHARGER_N);
      charger_port_detect <= k[0];
      cyc(2);
      pin(k < 2 ? {1'b0, k[0]} : {!k[0], !k[0]});
    end
    start(`OPT_TIMESTAMP);
    last = config_pin_out;
    repeat (3) begin
      sof_received <= 1'b1;
      cyc(1);
      sof_received <= 1'b0;
      cyc(3);
      last = !last;
      pin({1'b0, last});
    end
    for (int k = 0; k < 2; k++) begin
      start(k ? `OPT_READ_STROBE : `OPT_WRITE_STROBE);
      proto_data_out <= 4'h3;
      proto_data_oe_n <= 4'h5;
      cyc(3);
      `CHK({interface_data_lines_oe_n, interface_data_lines_out}, 8'h53)
      wr(`REG_PORT_DIR, 32'h0000_0003);
      wr(`REG_CONTROL, 32'h0000_0020);
      ext_word <= 4'hA;
      cyc(2);
      f = falls;
      wr(`REG_PORT_OUT, 32'h0000_0005);
      cyc(4);
      `CHK(8'(falls - f), 8'h01)
      `CHK({interface_data_lines_oe_n, interface_data_lines_out[1:0]}, 6'h31)
      ext_word <= 4'h4;
      cyc(4);
      rd(`REG_PORT_IN, d);
      `CHK(d[3:2], 2'h2)
      rdc(`REG_PORT_OUT, 32'h0000_0005);
    end
    start(`OPT_WRITE_STROBE);
    wr(`REG_PRESCALE, 32'h0000_0028);
    wr(`REG_PORT_DIR, 32'h0000_000F);
    wr(`REG_CONTROL, 32'h0000_0010);
    f = falls;
    wr(`REG_PORT_OUT, 32'h0000_0009);
    wait_word(4'h9, n);
    wr(`REG_PORT_OUT, 32'h0000_0006);
    wait_word(4'h6, n);
    `CHK(n + 1, 41)
    cyc(2);
    `CHK(8'(falls - f), 8'h02)
    rdc(`REG_STATUS, 32'h0000_00B1);
    results();
  end
endmodule // test_cbus_pin_function_select

bind cbus_pin_function_select cbus_pin_monitor i_mon (.clk, .rst, .option_code,
  .usb_configured, .usb_suspend, .charger_port_detect, .sof_received, .config_pin_in,
  .config_pin_out, .config_pin_oe_n, .bus_power_detect, .suspend_inhibit, .reg_read,
  .reg_rdata);
